// >>> adl_defines.vh
`ifndef ADL_DEFINES_VH
`define ADL_DEFINES_VH

// Framing control bytes.
`define ADL_ENQ 8'h05
`define ADL_EOT 8'h04
`define ADL_ACK 8'h06
`define ADL_NAK 8'h15

// Command letters.
`define ADL_CMD_READ 8'h52
`define ADL_CMD_WRITE 8'h57
`define ADL_CMD_MON_REG 8'h58
`define ADL_CMD_MON_ACT 8'h59

// Two-character error codes, high character first.
`define ADL_ERR_UNKNOWN_FUNC 16'h4946
`define ADL_ERR_MISSING_ADDRESS 16'h4941
`define ADL_ERR_VALUE_OUT_OF_RANGE 16'h4944
`define ADL_ERR_WRITE_NOT_PERMITTED 16'h574D
`define ADL_ERR_FRAME_OR_CHECKSUM 16'h4645

// Buffer sizes and word counts.
`define ADL_RX_BUF_LEN 44
`define ADL_TX_BUF_LEN 39
`define ADL_MON_WORDS 8
`define ADL_MAX_WORDS 4'h8

// Stored request lengths, delimiters excluded.
`define ADL_LEN_MIN_ECHO 6'h03
`define ADL_LEN_MIN_FRAME 6'h05
`define ADL_LEN_READ 6'h0A
`define ADL_LEN_WRITE_BASE 6'h0A
`define ADL_LEN_MON_REG_BASE 6'h06
`define ADL_LEN_MON_ACT 6'h05

// Line rate selection.
`define ADL_CLK_HZ 25000000
`define ADL_BAUD_BASE 1200
`define ADL_BAUD_SEL_MAX 3'h4
`define ADL_BAUD_SEL_DEFAULT 3'h3

// Protocol select value for this ASCII protocol.
`define ADL_PROTO_ASCII 1'b1

`endif

// >>> adl_hex_field.v
`timescale 1ns/1ns
`default_nettype none

module adl_hex_field #(
    parameter N = 4
) (
    // Characters, first sent in the top byte.
    input wire [8*N-1:0] chars_in,
    // Decoded value and validity.
    output reg [4*N-1:0] value_out,
    output reg valid_out
);
    integer k;
    reg [7:0] c;

    always @* begin
        value_out = {4*N{1'b0}};
        valid_out = 1'b1;
        c = 8'h00;
        for (k = 0; k < N; k = k + 1) begin
            c = chars_in[8*k +: 8];
            // Only 0-9 and upper-case A-F are digits.
            if (c >= 8'h30 && c <= 8'h39) begin
                value_out[4*k +: 4] = c[3:0];
            end else if (c >= 8'h41 && c <= 8'h46) begin
                value_out[4*k +: 4] = c[3:0] + 4'h9;
            end else begin
                valid_out = 1'b0;
            end
        end
    end
endmodule // adl_hex_field

`default_nettype wire

// >>> adl_baud_gen.v
`timescale 1ns/1ns
`default_nettype none
`include "adl_defines.vh"

module adl_baud_gen #(
    parameter CLK_HZ = `ADL_CLK_HZ
) (
    // Clock and reset.
    input wire clock_in,
    input wire reset_n_in,
    // Rate select and bit-rate enable.
    input wire [2:0] baud_sel_in,
    output reg baud_tick_out
);
    wire [2:0] sel;
    wire [31:0] divisor;
    reg [15:0] count_reg;

    // Codes above the top rate fall back to the default 9600 rate.
    assign sel = (baud_sel_in > `ADL_BAUD_SEL_MAX) ?
        `ADL_BAUD_SEL_DEFAULT : baud_sel_in;
    assign divisor = CLK_HZ / (`ADL_BAUD_BASE << sel);

    always @(posedge clock_in) begin
        if (!reset_n_in) begin
            count_reg <= 16'h0000;
            baud_tick_out <= 1'b0;
        end else if (count_reg >= divisor[15:0] - 16'h0001) begin
            count_reg <= 16'h0000;
            baud_tick_out <= 1'b1;
        end else begin
            count_reg <= count_reg + 16'h0001;
            baud_tick_out <= 1'b0;
        end
    end
endmodule // adl_baud_gen

`default_nettype wire

// >>> adl_link_slave.v
`timescale 1ns/1ns
`default_nettype none
`include "adl_defines.vh"

module adl_link_slave #(
    parameter CLK_HZ = `ADL_CLK_HZ
) (
    // Clock and reset.
    input wire clock_in,
    input wire reset_n_in,
    // Received bytes from the character receiver.
    input wire [7:0] rx_data_in,
    input wire rx_valid_in,
    // Bytes to the character transmitter.
    output reg [7:0] tx_data_out,
    output wire tx_valid_out,
    input wire tx_ready_in,
    // Configuration.
    input wire [7:0] station_id_in,
    input wire protocol_sel_in,
    input wire [2:0] baud_sel_in,
    output wire baud_tick_out,
    output wire link_busy_out,
    // Parameter map access.
    output reg [15:0] par_addr_out,
    output reg [15:0] par_wdata_out,
    output reg par_wr_out,
    input wire [15:0] par_rdata_in,
    input wire par_exists_in,
    input wire par_writable_in,
    input wire par_in_range_in
);
    localparam S_RX = 3'h0;
    localparam S_CHECK = 3'h1;
    localparam S_ACCESS = 3'h2;
    localparam S_BUILD = 3'h3;
    localparam S_SEND = 3'h4;

    reg [2:0] state_reg;
    reg [7:0] rx_buf_reg [0:`ADL_RX_BUF_LEN-1];
    reg [7:0] tx_buf_reg [0:`ADL_TX_BUF_LEN-1];
    reg [15:0] data_reg [0:`ADL_MON_WORDS-1];
    reg [15:0] mon_reg [0:`ADL_MON_WORDS-1];
    reg [5:0] rx_len_reg;
    reg collect_reg, ovf_reg;
    reg [7:0] sum0_reg, sum1_reg, sum2_reg;
    reg [3:0] n_reg, idx_reg;
    reg pass_reg, phase_reg, nack_reg;
    reg [15:0] err_reg;
    reg [3:0] nwords_reg, mon_cnt_reg;
    reg first_done_reg;
    reg [5:0] bidx_reg;
    reg [7:0] tx_sum_reg;
    reg [5:0] tx_len_reg, tx_ptr_reg;
    integer m;

    function [7:0] hex_char;
        input [3:0] nib;
        begin
            hex_char = (nib < 4'hA) ? (8'h30 + {4'h0, nib}) :
                (8'h37 + {4'h0, nib});
        end
    endfunction

    adl_baud_gen #(
        .CLK_HZ(CLK_HZ)
    ) u_baud (
        .clock_in(clock_in),
        .reset_n_in(reset_n_in),
        .baud_sel_in(baud_sel_in),
        .baud_tick_out(baud_tick_out)
    );

    // Request field decoding.
    wire [7:0] cmd = rx_buf_reg[2];
    wire is_r = (cmd == `ADL_CMD_READ);
    wire is_w = (cmd == `ADL_CMD_WRITE);
    wire is_x = (cmd == `ADL_CMD_MON_REG);
    wire is_y = (cmd == `ADL_CMD_MON_ACT);
    wire cmd_ok = is_r | is_w | is_x | is_y;
    wire [7:0] st_val, chk_val;
    wire [3:0] n_val;
    wire [15:0] addr_val, word_val;
    wire st_valid, chk_valid, n_valid, addr_valid, word_valid;
    wire [5:0] wpos = (is_w ? 6'h08 : 6'h04) + {idx_reg, 2'b00};

    adl_hex_field #(.N(2)) u_station (
        .chars_in({rx_buf_reg[0], rx_buf_reg[1]}),
        .value_out(st_val),
        .valid_out(st_valid)
    );
    adl_hex_field #(.N(2)) u_chk (
        .chars_in({rx_buf_reg[rx_len_reg - 6'h02],
            rx_buf_reg[rx_len_reg - 6'h01]}),
        .value_out(chk_val),
        .valid_out(chk_valid)
    );
    adl_hex_field #(.N(1)) u_count (
        .chars_in(is_x ? rx_buf_reg[3] : rx_buf_reg[7]),
        .value_out(n_val),
        .valid_out(n_valid)
    );
    adl_hex_field #(.N(4)) u_addr (
        .chars_in({rx_buf_reg[3], rx_buf_reg[4], rx_buf_reg[5],
            rx_buf_reg[6]}),
        .value_out(addr_val),
        .valid_out(addr_valid)
    );
    adl_hex_field #(.N(4)) u_word (
        .chars_in({rx_buf_reg[wpos], rx_buf_reg[wpos + 6'h01],
            rx_buf_reg[wpos + 6'h02], rx_buf_reg[wpos + 6'h03]}),
        .value_out(word_val),
        .valid_out(word_valid)
    );

    wire n_ok = n_valid && n_val != 4'h0 && n_val <= `ADL_MAX_WORDS;
    wire [5:0] exp_len = is_r ? `ADL_LEN_READ :
        is_w ? `ADL_LEN_WRITE_BASE + {n_val, 2'b00} :
        is_x ? `ADL_LEN_MON_REG_BASE + {n_val, 2'b00} :
        `ADL_LEN_MON_ACT;
    wire station_ok = rx_len_reg >= `ADL_LEN_MIN_ECHO && st_valid &&
        st_val == station_id_in;
    wire sum_ok = !ovf_reg && rx_len_reg >= `ADL_LEN_MIN_FRAME &&
        chk_valid && chk_val == sum2_reg;
    wire [15:0] acc_addr = is_y ? mon_reg[idx_reg[2:0]] :
        is_x ? word_val : addr_val + {12'h000, idx_reg};
    wire fmt_ok = is_y ? 1'b1 : is_x ? word_valid :
        (addr_valid && (!is_w || word_valid));
    wire last_word = (idx_reg == n_reg - 4'h1);

    // Reply byte at the build cursor.
    wire [5:0] dcount = nack_reg ? 6'h02 : {nwords_reg, 2'b00};
    wire [5:0] j = bidx_reg - 6'h04;
    wire [15:0] dword = data_reg[j[4:2]];
    wire [3:0] dnib = (j[1:0] == 2'h0) ? dword[15:12] :
        (j[1:0] == 2'h1) ? dword[11:8] :
        (j[1:0] == 2'h2) ? dword[7:4] : dword[3:0];
    reg [7:0] build_byte;

    always @* begin
        if (bidx_reg == 6'h00) begin
            build_byte = nack_reg ? `ADL_NAK : `ADL_ACK;
        end else if (bidx_reg < 6'h04) begin
            build_byte = rx_buf_reg[bidx_reg - 6'h01];
        end else if (bidx_reg < 6'h04 + dcount) begin
            if (nack_reg) begin
                build_byte = j[0] ? err_reg[7:0] : err_reg[15:8];
            end else begin
                build_byte = hex_char(dnib);
            end
        end else if (bidx_reg == 6'h04 + dcount) begin
            build_byte = hex_char(tx_sum_reg[7:4]);
        end else if (bidx_reg == 6'h05 + dcount) begin
            build_byte = hex_char(tx_sum_reg[3:0]);
        end else begin
            build_byte = `ADL_EOT;
        end
    end

    assign tx_valid_out = (state_reg == S_SEND);
    assign link_busy_out = (state_reg != S_RX);

    always @(posedge clock_in) begin
        if (!reset_n_in) begin
            state_reg <= S_RX;
            rx_len_reg <= 6'h00;
            collect_reg <= 1'b0;
            ovf_reg <= 1'b0;
            sum0_reg <= 8'h00;
            sum1_reg <= 8'h00;
            sum2_reg <= 8'h00;
            n_reg <= 4'h0;
            idx_reg <= 4'h0;
            pass_reg <= 1'b0;
            phase_reg <= 1'b0;
            nack_reg <= 1'b0;
            err_reg <= 16'h0000;
            nwords_reg <= 4'h0;
            mon_cnt_reg <= 4'h0;
            first_done_reg <= 1'b0;
            bidx_reg <= 6'h00;
            tx_sum_reg <= 8'h00;
            tx_len_reg <= 6'h00;
            tx_ptr_reg <= 6'h00;
            tx_data_out <= 8'h00;
            par_addr_out <= 16'h0000;
            par_wdata_out <= 16'h0000;
            par_wr_out <= 1'b0;
        end else begin
            par_wr_out <= 1'b0;
            case (state_reg)
            S_RX: begin
                // Each received byte is one 8-bit character.
                if (protocol_sel_in != `ADL_PROTO_ASCII) begin
                    collect_reg <= 1'b0;
                end else if (rx_valid_in) begin
                    if (rx_data_in == `ADL_ENQ) begin
                        collect_reg <= 1'b1;
                        rx_len_reg <= 6'h00;
                        ovf_reg <= 1'b0;
                        sum0_reg <= 8'h00;
                        sum1_reg <= 8'h00;
                        sum2_reg <= 8'h00;
                    end else if (collect_reg) begin
                        if (rx_data_in == `ADL_EOT) begin
                            collect_reg <= 1'b0;
                            state_reg <= S_CHECK;
                        end else if (rx_len_reg < `ADL_RX_BUF_LEN) begin
                            rx_buf_reg[rx_len_reg] <= rx_data_in;
                            rx_len_reg <= rx_len_reg + 6'h01;
                            sum0_reg <= sum0_reg + rx_data_in;
                            sum1_reg <= sum0_reg;
                            sum2_reg <= sum1_reg;
                        end else begin
                            ovf_reg <= 1'b1;
                        end
                    end
                end
            end
            S_CHECK: begin
                idx_reg <= 4'h0;
                pass_reg <= 1'b0;
                phase_reg <= 1'b0;
                bidx_reg <= 6'h00;
                tx_sum_reg <= 8'h00;
                nack_reg <= 1'b1;
                n_reg <= is_y ? mon_cnt_reg : n_val;
                if (!station_ok) begin
                    state_reg <= S_RX;
                end else if (!sum_ok) begin
                    err_reg <= `ADL_ERR_FRAME_OR_CHECKSUM;
                    state_reg <= S_BUILD;
                end else if (!cmd_ok) begin
                    err_reg <= `ADL_ERR_UNKNOWN_FUNC;
                    state_reg <= S_BUILD;
                end else if ((!is_y && !n_ok) || rx_len_reg != exp_len) begin
                    err_reg <= `ADL_ERR_FRAME_OR_CHECKSUM;
                    state_reg <= S_BUILD;
                end else if (is_y && mon_cnt_reg == 4'h0) begin
                    nack_reg <= 1'b0;
                    nwords_reg <= 4'h0;
                    state_reg <= S_BUILD;
                end else begin
                    state_reg <= S_ACCESS;
                end
            end
            S_ACCESS: begin
                if (!phase_reg) begin
                    par_addr_out <= acc_addr;
                    par_wdata_out <= word_val;
                    par_wr_out <= is_w && pass_reg && fmt_ok;
                    phase_reg <= 1'b1;
                    if (!fmt_ok) begin
                        err_reg <= `ADL_ERR_FRAME_OR_CHECKSUM;
                        state_reg <= S_BUILD;
                    end
                end else begin
                    phase_reg <= 1'b0;
                    idx_reg <= idx_reg + 4'h1;
                    if (!par_exists_in) begin
                        err_reg <= `ADL_ERR_MISSING_ADDRESS;
                        state_reg <= S_BUILD;
                    end else if (is_w && !pass_reg && !par_writable_in) begin
                        err_reg <= `ADL_ERR_WRITE_NOT_PERMITTED;
                        state_reg <= S_BUILD;
                    end else if (is_w && !pass_reg && !par_in_range_in) begin
                        // Nothing is written until every word passes.
                        err_reg <= `ADL_ERR_VALUE_OUT_OF_RANGE;
                        state_reg <= S_BUILD;
                    end else begin
                        if (is_x) begin
                            data_reg[idx_reg[2:0]] <= par_addr_out;
                        end else if (!is_w || !pass_reg) begin
                            data_reg[idx_reg[2:0]] <= par_rdata_in;
                        end else if (first_done_reg) begin
                            data_reg[idx_reg[2:0]] <= par_wdata_out;
                        end
                        if (last_word && is_w && !pass_reg) begin
                            pass_reg <= 1'b1;
                            idx_reg <= 4'h0;
                        end else if (last_word) begin
                            nack_reg <= 1'b0;
                            nwords_reg <= is_x ? 4'h0 : n_reg;
                            first_done_reg <= first_done_reg | is_w;
                            if (is_x) begin
                                mon_cnt_reg <= n_reg;
                            end
                            state_reg <= S_BUILD;
                        end
                    end
                end
            end
            S_BUILD: begin
                tx_buf_reg[bidx_reg] <= build_byte;
                bidx_reg <= bidx_reg + 6'h01;
                if (bidx_reg != 6'h00 && bidx_reg < 6'h04 + dcount) begin
                    tx_sum_reg <= tx_sum_reg + build_byte;
                end
                if (bidx_reg == 6'h06 + dcount) begin
                    tx_len_reg <= bidx_reg;
                    tx_ptr_reg <= 6'h00;
                    tx_data_out <= tx_buf_reg[0];
                    state_reg <= S_SEND;
                end
            end
            S_SEND: begin
                if (tx_ready_in) begin
                    if (tx_ptr_reg == tx_len_reg) begin
                        state_reg <= S_RX;
                    end else begin
                        tx_ptr_reg <= tx_ptr_reg + 6'h01;
                        tx_data_out <= tx_buf_reg[tx_ptr_reg + 6'h01];
                    end
                end
            end
            default: begin
                state_reg <= S_RX;
            end
            endcase
            // Copy the validated list only once the X request succeeds.
            if (state_reg == S_ACCESS && phase_reg && is_x && last_word &&
                    par_exists_in) begin
                for (m = 0; m < `ADL_MON_WORDS; m = m + 1) begin
                    if (m < idx_reg) begin
                        mon_reg[m] <= data_reg[m];
                    end else if (m == idx_reg) begin
                        mon_reg[m] <= par_addr_out;
                    end
                end
            end
        end
    end
endmodule // adl_link_slave

`default_nettype wire

// >>> adl_link_slave_sva.sv
`timescale 1ns/1ns
`default_nettype none
`include "adl_defines.vh"
module adl_link_slave_sva #(
    parameter CLK_HZ = `ADL_CLK_HZ
) (
    // Clock and reset.
    input wire logic clock_in,
    input wire logic reset_n_in,
    // Byte streams and configuration.
    input wire logic [7:0] rx_data_in,
    input wire logic rx_valid_in,
    input wire logic [7:0] tx_data_out,
    input wire logic tx_valid_out,
    input wire logic tx_ready_in,
    input wire logic [7:0] station_id_in,
    input wire logic protocol_sel_in,
    input wire logic [2:0] baud_sel_in,
    input wire logic baud_tick_out,
    input wire logic link_busy_out,
    // Parameter map.
    input wire logic [15:0] par_addr_out,
    input wire logic [15:0] par_wdata_out,
    input wire logic par_wr_out,
    input wire logic [15:0] par_rdata_in,
    input wire logic par_exists_in,
    input wire logic par_writable_in,
    input wire logic par_in_range_in
);
    // Counts reply bytes taken and keeps the reply's opening byte.
    logic [5:0] cnt_reg;
    logic [7:0] first_reg;
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!reset_n_in);
    always @(posedge clock_in) begin
        if (!reset_n_in || !tx_valid_out) begin
            cnt_reg <= 6'h00;
        end else if (tx_ready_in) begin
            cnt_reg <= cnt_reg + 6'h01;
        end
        if (tx_valid_out && cnt_reg == 6'h00) begin
            first_reg <= tx_data_out;
        end
    end
    chk_reply_start: assert property ($rose(tx_valid_out) |->
        tx_data_out == `ADL_ACK || tx_data_out == `ADL_NAK)
        else $error("reply opens with a wrong byte");
    chk_reply_end: assert property ($fell(tx_valid_out) |->
        $past(tx_data_out) == `ADL_EOT) else $error("reply not closed");
    chk_data_hold: assert property (tx_valid_out && !tx_ready_in |=>
        tx_valid_out && $stable(tx_data_out)) else $error("byte dropped");
    chk_reply_busy: assert property (tx_valid_out |-> link_busy_out)
        else $error("reply while idle");
    chk_nak_length: assert property ($fell(tx_valid_out) &&
        first_reg == `ADL_NAK |-> cnt_reg == 6'h09)
        else $error("negative reply length wrong");
    chk_ack_length: assert property ($fell(tx_valid_out) &&
        first_reg == `ADL_ACK |-> cnt_reg >= 6'h07 && cnt_reg <= 6'h27
        && cnt_reg[1:0] == 2'h3) else $error("reply length wrong");
    chk_text_chars: assert property (tx_valid_out && cnt_reg != 6'h00 &&
        tx_data_out != `ADL_EOT |-> tx_data_out inside {[8'h20:8'h7F]})
        else $error("unprintable reply character");
    chk_write_legal: assert property (par_wr_out |-> par_exists_in &&
        par_writable_in && par_in_range_in ##1 !par_wr_out)
        else $error("illegal write strobe");
    chk_proto_off: assert property (!protocol_sel_in && !link_busy_out
        |=> !link_busy_out) else $error("active with protocol off");
    chk_tick_pulse: assert property (baud_tick_out |=> !baud_tick_out)
        else $error("rate tick too long");
    cover property ($fell(tx_valid_out) && first_reg == `ADL_ACK);
    cover property ($fell(tx_valid_out) && first_reg == `ADL_NAK);
    cover property (par_wr_out);
    cover property (tx_valid_out && !tx_ready_in);
endmodule // adl_link_slave_sva
bind adl_link_slave adl_link_slave_sva #(.CLK_HZ(CLK_HZ)) u_adl_link_slave_sva (
    .clock_in(clock_in), .reset_n_in(reset_n_in), .rx_data_in(rx_data_in),
    .rx_valid_in(rx_valid_in), .tx_data_out(tx_data_out),
    .tx_valid_out(tx_valid_out), .tx_ready_in(tx_ready_in),
    .station_id_in(station_id_in), .protocol_sel_in(protocol_sel_in),
    .baud_sel_in(baud_sel_in), .baud_tick_out(baud_tick_out),
    .link_busy_out(link_busy_out), .par_addr_out(par_addr_out),
    .par_wdata_out(par_wdata_out), .par_wr_out(par_wr_out),
    .par_rdata_in(par_rdata_in), .par_exists_in(par_exists_in),
    .par_writable_in(par_writable_in), .par_in_range_in(par_in_range_in));
`default_nettype wire

// >>> adl_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module adl_host_model (
    // Clock.
    input wire logic clock_in,
    // Request and reply bytes.
    output logic [7:0] rx_data_out,
    output logic rx_valid_out,
    input wire logic [7:0] tx_data_in,
    input wire logic tx_valid_in,
    output logic tx_ready_out,
    // Parameter map answers.
    input wire logic [15:0] par_addr_in,
    input wire logic [15:0] par_wdata_in,
    input wire logic par_wr_in,
    output logic [15:0] par_rdata_out,
    output logic par_exists_out,
    output logic par_writable_out,
    output logic par_in_range_out
);
    // Sixteen words at 0000h-000Fh, 0003h read-only, values below 1000h legal.
    logic [15:0] mem [0:15];
    logic [7:0] got_q[$];
    logic slow = 1'b0;
    initial begin
        rx_data_out = 8'h00;
        rx_valid_out = 1'b0;
        tx_ready_out = 1'b1;
        for (int i = 0; i < 16; i++) begin
            mem[i] = 16'h0100 + 16'(i);
        end
    end
    assign par_exists_out = par_addr_in < 16'h0010;
    assign par_writable_out = par_addr_in != 16'h0003;
    assign par_in_range_out = par_wdata_in < 16'h1000;
    assign par_rdata_out = par_exists_out ? mem[par_addr_in[3:0]] : ~par_addr_in;
    always @(posedge clock_in) begin
        if (par_wr_in && par_exists_out) begin
            mem[par_addr_in[3:0]] <= par_wdata_in;
        end
        if (tx_valid_in && tx_ready_out) begin
            got_q.push_back(tx_data_in);
        end
        tx_ready_out <= slow ? ~tx_ready_out : 1'b1;
    end
    function automatic logic [7:0] hexc(input logic [3:0] v);
        return (v < 4'hA) ? 8'h30 + {4'h0, v} : 8'h37 + {4'h0, v};
    endfunction
    function automatic logic [7:0] csum(input logic [7:0] stn, cmd,
                                        input string body);
        logic [7:0] s;
        s = hexc(stn[7:4]) + hexc(stn[3:0]) + cmd;
        foreach (body[i]) s += body[i];
        return s;
    endfunction
    task automatic send_byte(input logic [7:0] b);
        @(posedge clock_in);
        rx_data_out <= b;
        rx_valid_out <= 1'b1;
    endtask
    task automatic send_frame(input logic [7:0] stn, cmd, input string body,
                              input bit bad);
        logic [7:0] s;
        s = csum(stn, cmd, body) ^ {7'h00, bad};
        got_q.delete();
        send_byte(8'h05);
        send_byte(hexc(stn[7:4]));
        send_byte(hexc(stn[3:0]));
        send_byte(cmd);
        foreach (body[i]) send_byte(body[i]);
        send_byte(hexc(s[7:4]));
        send_byte(hexc(s[3:0]));
        send_byte(8'h04);
        @(posedge clock_in);
        rx_valid_out <= 1'b0;
        rx_data_out <= 8'hFB;
    endtask
endmodule // adl_host_model
`default_nettype wire

// >>> adl_link_slave_bench.sv
`timescale 1ns/1ns
`default_nettype none
module adl_link_slave_bench;
    localparam int CLK_HZ = 153600;
    logic clock_in, reset_n_in, protocol_sel_in;
    logic [7:0] station_id_in;
    logic [2:0] baud_sel_in;
    wire [7:0] rx_data, tx_data;
    wire [15:0] p_addr, p_wdata, p_rdata;
    wire rx_valid, tx_valid, tx_ready, p_wr, p_ex, p_wt, p_rg, busy, tick;
    int n_mismatch = 0;
    int cmp_count = 0;
    logic [7:0] exp_q[$];
    initial begin
        clock_in = 1'b0;
        forever #20 clock_in = ~clock_in;
    end
    adl_link_slave #(.CLK_HZ(CLK_HZ)) u_adl_link_slave (
        .clock_in(clock_in), .reset_n_in(reset_n_in), .rx_data_in(rx_data),
        .rx_valid_in(rx_valid), .tx_data_out(tx_data),
        .tx_valid_out(tx_valid), .tx_ready_in(tx_ready),
        .station_id_in(station_id_in), .protocol_sel_in(protocol_sel_in),
        .baud_sel_in(baud_sel_in), .baud_tick_out(tick),
        .link_busy_out(busy), .par_addr_out(p_addr), .par_wdata_out(p_wdata),
        .par_wr_out(p_wr), .par_rdata_in(p_rdata), .par_exists_in(p_ex),
        .par_writable_in(p_wt), .par_in_range_in(p_rg));
    adl_host_model u_adl_host_model (
        .clock_in(clock_in), .rx_data_out(rx_data), .rx_valid_out(rx_valid),
        .tx_data_in(tx_data), .tx_valid_in(tx_valid), .tx_ready_out(tx_ready),
        .par_addr_in(p_addr), .par_wdata_in(p_wdata), .par_wr_in(p_wr),
        .par_rdata_out(p_rdata), .par_exists_out(p_ex),
        .par_writable_out(p_wt), .par_in_range_out(p_rg));
    task automatic cmp8(input string what, input logic [7:0] exp, got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cmp16(input string what, input logic [15:0] exp, got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Sends one request and compares the whole reply; kind 0 means silence.
    task automatic exchange(input logic [7:0] stn, cmd, input string body,
                            input bit bad, input logic [7:0] kind,
                            input string data);
        logic [7:0] s;
        exp_q.delete();
        s = u_adl_host_model.csum(stn, cmd, data);
        if (kind != 8'h00) begin
            exp_q = {kind, u_adl_host_model.hexc(stn[7:4]),
                     u_adl_host_model.hexc(stn[3:0]), cmd};
            foreach (data[i]) exp_q.push_back(data[i]);
            exp_q.push_back(u_adl_host_model.hexc(s[7:4]));
            exp_q.push_back(u_adl_host_model.hexc(s[3:0]));
            exp_q.push_back(8'h04);
        end
        u_adl_host_model.send_frame(stn, cmd, body, bad);
        for (int j = 0; j < 4000; j++) begin
            @(negedge clock_in);
            if (kind == 8'h00 ? j == 200 : (busy === 1'b0 &&
                u_adl_host_model.got_q.size() > 0 &&
                u_adl_host_model.got_q[$] === 8'h04)) break;
        end
        cmp8("reply length", 8'(exp_q.size()),
             8'(u_adl_host_model.got_q.size()));
        foreach (exp_q[i]) cmp8("reply byte", exp_q[i],
                                u_adl_host_model.got_q[i]);
    endtask
    task automatic t_read;
        u_adl_host_model.slow = 1'b1;
        exchange(8'h01, "R", "00022", 0, 8'h06, "01020103");
        exchange(8'h01, "R", "00088", 0, 8'h06,
                 "01080109010A010B010C010D010E010F");
        u_adl_host_model.slow = 1'b0;
    endtask
    task automatic t_errors;
        exchange(8'h01, "Q", "00011", 0, 8'h15, "IF");
        exchange(8'h01, 8'h72, "00011", 0, 8'h15, "IF");
        exchange(8'h01, "R", "00011", 1, 8'h15, "FE");
        exchange(8'h01, "R", "0001", 0, 8'h15, "FE");
        exchange(8'h01, "R", "00201", 0, 8'h15, "IA");
    endtask
    task automatic t_silent;
        exchange(8'h02, "R", "00011", 0, 8'h00, "");
        @(posedge clock_in);
        protocol_sel_in <= 1'b0;
        exchange(8'h01, "R", "00011", 0, 8'h00, "");
        @(posedge clock_in);
        protocol_sel_in <= 1'b1;
    endtask
    task automatic t_write;
        exchange(8'h01, "W", "000510ABC", 0, 8'h06, "0105");
        cmp16("word 5", 16'h0ABC, u_adl_host_model.mem[5]);
        exchange(8'h01, "W", "0005201230456", 0, 8'h06,
                 "01230456");
        cmp16("word 6", 16'h0456, u_adl_host_model.mem[6]);
    endtask
    task automatic t_refuse;
        exchange(8'h01, "W", "0005201112000", 0, 8'h15, "ID");
        cmp16("word 5", 16'h0123, u_adl_host_model.mem[5]);
        exchange(8'h01, "W", "000310001", 0, 8'h15, "WM");
    endtask
    task automatic t_monitor;
        exchange(8'h01, "X", "200070001", 0, 8'h06, "");
        exchange(8'h01, "Y", "", 0, 8'h06, "01070101");
    endtask
    task automatic t_restart;
        u_adl_host_model.send_byte(8'h05);
        u_adl_host_model.send_byte("0");
        u_adl_host_model.send_byte("R");
        exchange(8'h01, "R", "00011", 0, 8'h06, "0101");
    endtask
    task automatic t_rate;
        int n = 0;
        repeat (160) @(negedge clock_in) n += tick;
        cmp8("rate ticks", 8'h0A, 8'(n));
    endtask
    task automatic report_and_stop;
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge clock_in);
        n_mismatch++;
        report_and_stop();
    end
    initial begin
        reset_n_in = 1'b0;
        protocol_sel_in = 1'b1;
        station_id_in = 8'h01;
        baud_sel_in = 3'h3;
        repeat (4) @(posedge clock_in);
        reset_n_in <= 1'b1;
        t_read();
        t_errors();
        t_silent();
        t_write();
        t_refuse();
        t_monitor();
        t_restart();
        t_rate();
        report_and_stop();
    end
endmodule // adl_link_slave_bench
`default_nettype wire
